// ===== logic/usbee_endpoint_engine.sv
// Purpose: usb endpoint engine, apb registers facing firmware
// Assumes: a serial engine decodes tokens and bytes into link_in_in
// Notes: one packet in flight at a time; buffers are flip-flops
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module usbee_endpoint_engine (
    input wire logic clock_in, // 25 MHz system clock
    input wire logic rst_in, // synchronous, active high
    input wire logic [usbee_pkg::ADDR_W-1:0] paddr_in, // apb address
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb enable
    input wire logic pwrite_in, // apb direction
    input wire logic [31:0] pwdata_in, // apb write data
    output logic [31:0] prdata_out, // apb read data
    output logic pready_out, // apb ready
    output logic pslverr_out, // apb error, unmapped address
    input wire usbee_pkg::usbee_link_in_s link_in_in, // decoded bus events
    output usbee_pkg::usbee_link_out_s link_out_out, // transmit side
    output logic irq_out // interrupt request
);
    import usbee_pkg::*;

    usbee_ep_s ep_r [NUM_EP];
    usbee_ep_s ep_nxt [NUM_EP];
    logic [7:0] mem_r [MEM_N];
    logic [7:0] mem_nxt [MEM_N];
    logic [EP_W-1:0] sel_r, sel_nxt, cur_r, cur_nxt;
    logic [1:0] ev_r, ev_nxt;
    logic [2:0] ien_r, ien_nxt;
    logic [10:0] frame_r, frame_nxt;
    logic fok_r, fok_nxt, ferr_r, ferr_nxt;
    usbee_link_e ls_r, ls_nxt;
    logic setup_pkt_r, setup_pkt_nxt;
    logic [CNT_W-1:0] idx_r, idx_nxt, tcnt_r, tcnt_nxt;
    usbee_link_out_s lo_r, lo_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, irq_r, irq_nxt;
    logic acc, wr;
    logic [7:0] wd;
    usbee_ep_s e, s;
    logic [CNT_W-1:0] rx_cnt;
    logic ep_any;

    function automatic int unsigned mi(logic [EP_W-1:0] ep, logic bank,
                                       logic [CNT_W-1:0] idx);
        return 32'({ep, bank, idx[IDX_W-1:0]});
    endfunction

    function automatic logic [7:0] status_of(usbee_ep_s x);
        logic [7:0] v;
        v = '0;
        v[ST_TXC] = x.tx_complete;
        v[ST_RX0] = x.rx_full[0];
        v[ST_SETUP] = x.setup_received;
        v[ST_STALL_OR_CRC_FLAG] = x.stall_or_crc_flag;
        v[ST_TXR] = x.tx_ready[x.fbank];
        v[ST_STALL_REQUEST] = x.stall_request;
        v[ST_RX1] = x.rx_full[1];
        v[ST_DIR] = x.dir;
        return v;
    endfunction

    function automatic usbee_ep_s ep_clear(usbee_ep_s x);
        usbee_ep_s v;
        v = '0;
        v.enable = x.enable;
        v.kind = x.kind;
        v.pingpong = x.pingpong;
        return v;
    endfunction

    always_comb begin
        ep_nxt = ep_r;
        mem_nxt = mem_r;
        sel_nxt = sel_r;
        cur_nxt = cur_r;
        ev_nxt = ev_r;
        ien_nxt = ien_r;
        frame_nxt = frame_r;
        fok_nxt = fok_r;
        ferr_nxt = ferr_r;
        ls_nxt = ls_r;
        setup_pkt_nxt = setup_pkt_r;
        idx_nxt = idx_r;
        tcnt_nxt = tcnt_r;
        lo_nxt = lo_r;
        lo_nxt.stall = 1'b0;
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        acc = psel_in & penable_in & pready_r;
        wr = acc & pwrite_in;
        wd = pwdata_in[7:0];
        pready_nxt = psel_in & penable_in & ~pready_r;
        s = ep_r[sel_r];
        rx_cnt = '0;
        ep_any = 1'b0;
        e = '0;

        // read data is latched one cycle before the accepting edge
        if (pready_nxt) begin
            prdata_nxt = '0;
            unique case (paddr_in)
                A_EVENT: prdata_nxt[1:0] = ev_r;
                A_SEL: prdata_nxt[EP_W-1:0] = sel_r;
                A_STATUS: prdata_nxt[7:0] = status_of(s);
                A_COUNT: prdata_nxt[CNT_W-1:0] = s.cnt[s.rbank];
                A_FLO: prdata_nxt[7:0] = frame_r[7:0];
                A_FHI: begin
                    prdata_nxt[2:0] = frame_r[10:8];
                    prdata_nxt[FH_OK] = fok_r;
                    prdata_nxt[FH_ERR] = ferr_r;
                end
                A_EPRST: prdata_nxt = '0;
                A_CFG: begin
                    prdata_nxt[CF_EN] = s.enable;
                    prdata_nxt[CF_TYPE+1:CF_TYPE] = s.kind;
                    prdata_nxt[CF_PP] = s.pingpong;
                end
                A_IEN: prdata_nxt[2:0] = ien_r;
                A_DATA: prdata_nxt[7:0] = mem_r[mi(sel_r, s.rbank, s.ptr)];
                default: pslverr_nxt = 1'b1;
            endcase
        end

        // firmware side: clears are applied before hardware sets below
        if (acc) begin
            e = ep_nxt[sel_r];
            if (wr) begin
                unique case (paddr_in)
                    A_EVENT: ev_nxt = ev_r & wd[1:0];
                    A_SEL: sel_nxt = wd[EP_W-1:0];
                    A_IEN: ien_nxt = wd[2:0];
                    A_CFG: begin
                        e.enable = wd[CF_EN];
                        e.kind = usbee_type_e'(wd[CF_TYPE+1:CF_TYPE]);
                        e.pingpong = wd[CF_PP];
                    end
                    A_STATUS: begin
                        e.tx_complete &= wd[ST_TXC];
                        e.setup_received &= wd[ST_SETUP];
                        e.stall_or_crc_flag &= wd[ST_STALL_OR_CRC_FLAG];
                        e.stall_request = wd[ST_STALL_REQUEST];
                        e.dir = wd[ST_DIR];
                        // clearing the flag of the read bank frees it
                        if (e.rx_full[e.rbank] &&
                            !wd[e.rbank ? ST_RX1 : ST_RX0]) begin
                            e.rx_full[e.rbank] = 1'b0;
                            e.ptr = '0;
                            e.rbank = e.pingpong & ~e.rbank;
                        end
                        e.rx_full[0] &= wd[ST_RX0];
                        e.rx_full[1] &= wd[ST_RX1];
                        // only a rising write arms, so a read-modify-write
                        // of the status does not swap banks twice
                        if (wd[ST_TXR] && !e.tx_ready[e.fbank]) begin
                            e.tx_ready[e.fbank] = 1'b1;
                            e.cnt[e.fbank] = e.ptr;
                            e.ptr = '0;
                            e.fbank = e.pingpong & ~e.fbank;
                        end
                    end
                    A_DATA: begin
                        // overfill is dropped; firmware must not do it
                        if (e.ptr < CNT_MAX) begin
                            mem_nxt[mi(sel_r, e.fbank, e.ptr)] = wd;
                            e.ptr = e.ptr + 1'b1;
                        end
                    end
                    default: ;
                endcase
            end else if (paddr_in == A_DATA && e.ptr < e.cnt[e.rbank]) begin
                e.ptr = e.ptr + 1'b1;
            end
            ep_nxt[sel_r] = e;
            if (wr && paddr_in == A_EPRST) begin
                for (int i = 0; i < NUM_EP; i++) begin
                    if (wd[i]) begin
                        ep_nxt[i] = ep_clear(ep_r[i]);
                    end
                end
            end
        end

        // transmit register drains on accept
        if (lo_r.tx_valid && link_in_in.tx_accept) begin
            lo_nxt.tx_valid = 1'b0;
            lo_nxt.tx_last = 1'b0;
        end

        e = ep_nxt[cur_r];
        unique case (ls_r)
            LS_IDLE: begin
                if (link_in_in.tok_valid) begin
                    cur_nxt = link_in_in.tok_ep;
                    e = ep_nxt[link_in_in.tok_ep];
                    idx_nxt = '0;
                    setup_pkt_nxt = link_in_in.tok_kind == TK_SETUP;
                    unique case (link_in_in.tok_kind)
                        TK_SOF: begin
                            ev_nxt[EV_SOF] = 1'b1;
                            frame_nxt = link_in_in.tok_frame;
                            fok_nxt = link_in_in.tok_crc_ok;
                            ferr_nxt = ~link_in_in.tok_crc_ok;
                        end
                        TK_SETUP: begin
                            if (e.enable && e.kind == EP_CTRL) begin
                                ls_nxt = LS_RX;
                            end
                        end
                        TK_OUT, TK_IN: begin
                            if (!e.enable) begin
                                ls_nxt = LS_IDLE;
                            end else if (e.stall_request &&
                                         e.kind != EP_ISO) begin
                                lo_nxt.stall = 1'b1;
                                e.stall_or_crc_flag = 1'b1;
                            end else if (link_in_in.tok_kind == TK_OUT) begin
                                ls_nxt = LS_RX;
                            end else if (e.tx_ready[e.sbank]) begin
                                ls_nxt = LS_TX;
                                tcnt_nxt = e.cnt[e.sbank];
                            end
                        end
                    endcase
                    ep_nxt[link_in_in.tok_ep] = e;
                end
            end
            LS_RX: begin
                rx_cnt = idx_r;
                // a full bank drops bytes; after a clear, storing resumes at the same index
                if (link_in_in.rx_valid && !e.rx_full[e.wbank]) begin
                    if (idx_r < CNT_MAX) begin
                        mem_nxt[mi(cur_r, e.wbank, idx_r)] =
                            link_in_in.rx_byte;
                        rx_cnt = idx_r + 1'b1;
                    end
                end
                idx_nxt = rx_cnt;
                if (link_in_in.rx_end) begin
                    ls_nxt = LS_IDLE;
                    if (setup_pkt_r) begin
                        if (link_in_in.rx_crc_ok) begin
                            e = ep_clear(e);
                            e.setup_received = 1'b1;
                            e.stall_request = 1'b0;
                            e.cnt[0] = rx_cnt;
                            e.toggle = ~link_in_in.rx_data1;
                        end
                    end else if (!e.rx_full[e.wbank] &&
                                 (link_in_in.rx_crc_ok ||
                                  e.kind == EP_ISO)) begin
                        e.rx_full[e.wbank] = 1'b1;
                        e.cnt[e.wbank] = rx_cnt;
                        if (e.kind == EP_ISO) begin
                            e.stall_or_crc_flag =
                                ~link_in_in.rx_crc_ok;
                        end
                        if (link_in_in.rx_crc_ok) begin
                            e.toggle = ~link_in_in.rx_data1;
                        end
                        e.wbank = e.pingpong & ~e.wbank;
                    end
                    ep_nxt[cur_r] = e;
                end
            end
            LS_TX: begin
                if (!lo_r.tx_valid || link_in_in.tx_accept) begin
                    if (idx_r < tcnt_r) begin
                        lo_nxt.tx_valid = 1'b1;
                        lo_nxt.tx_byte = mem_r[mi(cur_r, e.sbank, idx_r)];
                        lo_nxt.tx_last = idx_r + 1'b1 == tcnt_r;
                        idx_nxt = idx_r + 1'b1;
                    end else begin
                        // no handshake is awaited, whatever the endpoint kind
                        e.tx_ready[e.sbank] = 1'b0;
                        e.tx_complete = 1'b1;
                        e.sbank = e.pingpong & ~e.sbank;
                        ep_nxt[cur_r] = e;
                        ls_nxt = LS_IDLE;
                    end
                end
            end
            default: ls_nxt = LS_IDLE;
        endcase

        // bus reset end: usb state and endpoint configuration cleared, interrupt enables kept
        if (link_in_in.bus_reset_end) begin
            for (int i = 0; i < NUM_EP; i++) begin
                ep_nxt[i] = '0;
            end
            sel_nxt = '0;
            frame_nxt = '0;
            fok_nxt = 1'b0;
            ferr_nxt = 1'b0;
            ls_nxt = LS_IDLE;
            lo_nxt = '0;
            ev_nxt[EV_EOR] = 1'b1;
        end

        for (int i = 0; i < NUM_EP; i++) begin
            ep_any |= ep_r[i].tx_complete | (|ep_r[i].rx_full) |
                      ep_r[i].setup_received | ep_r[i].stall_or_crc_flag;
        end
        irq_nxt = (|(ev_r & ien_r[1:0])) | (ep_any & ien_r[IE_EP]);
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            for (int i = 0; i < NUM_EP; i++) begin
                ep_r[i] <= '0;
            end
            for (int i = 0; i < MEM_N; i++) begin
                mem_r[i] <= '0;
            end
            sel_r <= '0;
            cur_r <= '0;
            ev_r <= '0;
            ien_r <= '0;
            frame_r <= '0;
            fok_r <= 1'b0;
            ferr_r <= 1'b0;
            ls_r <= LS_IDLE;
            setup_pkt_r <= 1'b0;
            idx_r <= '0;
            tcnt_r <= '0;
            lo_r <= '0;
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            ep_r <= ep_nxt;
            mem_r <= mem_nxt;
            sel_r <= sel_nxt;
            cur_r <= cur_nxt;
            ev_r <= ev_nxt;
            ien_r <= ien_nxt;
            frame_r <= frame_nxt;
            fok_r <= fok_nxt;
            ferr_r <= ferr_nxt;
            ls_r <= ls_nxt;
            setup_pkt_r <= setup_pkt_nxt;
            idx_r <= idx_nxt;
            tcnt_r <= tcnt_nxt;
            lo_r <= lo_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt & pready_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign link_out_out = lo_r;
    assign irq_out = irq_r;
endmodule
`default_nettype wire

// ===== logic/usbee_pkg.sv
// Purpose: shared constants and carriers of the usb endpoint engine
// Assumes: apb byte addresses, 32-bit data, registers in the low byte
// Notes: sizes of the endpoint buffers are fixed here for the structs
package usbee_pkg;
    localparam int NUM_EP = 4;
    localparam int EP_W = 2;
    localparam int DEPTH = 8;
    localparam int IDX_W = 3;
    localparam int CNT_W = 4;
    localparam int ADDR_W = 8;
    localparam int MEM_N = NUM_EP * 2 * DEPTH;
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(DEPTH);

    localparam logic [ADDR_W-1:0] A_EVENT = 8'h00;
    localparam logic [ADDR_W-1:0] A_SEL = 8'h04;
    localparam logic [ADDR_W-1:0] A_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] A_COUNT = 8'h0C;
    localparam logic [ADDR_W-1:0] A_FLO = 8'h10;
    localparam logic [ADDR_W-1:0] A_FHI = 8'h14;
    localparam logic [ADDR_W-1:0] A_EPRST = 8'h18;
    localparam logic [ADDR_W-1:0] A_CFG = 8'h1C;
    localparam logic [ADDR_W-1:0] A_IEN = 8'h20;
    localparam logic [ADDR_W-1:0] A_DATA = 8'h24;

    localparam int ST_TXC = 0;
    localparam int ST_RX0 = 1;
    localparam int ST_SETUP = 2;
    localparam int ST_STALL_OR_CRC_FLAG = 3;
    localparam int ST_TXR = 4;
    localparam int ST_STALL_REQUEST = 5;
    localparam int ST_RX1 = 6;
    localparam int ST_DIR = 7;
    localparam int EV_EOR = 0;
    localparam int EV_SOF = 1;
    localparam int IE_EP = 2;
    localparam int CF_EN = 0;
    localparam int CF_TYPE = 1;
    localparam int CF_PP = 3;
    localparam int FH_OK = 3;
    localparam int FH_ERR = 4;

    typedef enum logic [1:0] {
        EP_CTRL = 2'b00, EP_ISO = 2'b01, EP_BULK = 2'b10, EP_INTR = 2'b11
    } usbee_type_e;
    typedef enum logic [1:0] {
        TK_OUT = 2'b00, TK_IN = 2'b01, TK_SETUP = 2'b10, TK_SOF = 2'b11
    } usbee_tok_e;
    typedef enum logic [1:0] {
        LS_IDLE = 2'b00, LS_RX = 2'b01, LS_TX = 2'b10
    } usbee_link_e;

    typedef struct packed {
        logic tok_valid;
        usbee_tok_e tok_kind;
        logic [EP_W-1:0] tok_ep;
        logic [10:0] tok_frame;
        logic tok_crc_ok;
        logic rx_valid;
        logic [7:0] rx_byte;
        logic rx_end;
        logic rx_crc_ok;
        logic rx_data1;
        logic bus_reset_end;
        logic tx_accept;
    } usbee_link_in_s;

    typedef struct packed {
        logic tx_valid;
        logic [7:0] tx_byte;
        logic tx_last;
        logic stall;
    } usbee_link_out_s;

    typedef struct packed {
        logic enable;
        usbee_type_e kind;
        logic pingpong;
        logic dir;
        logic stall_request;
        logic setup_received;
        logic stall_or_crc_flag;
        logic tx_complete;
        logic [1:0] rx_full;
        logic [1:0] tx_ready;
        logic wbank;
        logic rbank;
        logic fbank;
        logic sbank;
        logic toggle;
        logic [CNT_W-1:0] ptr;
        logic [1:0][CNT_W-1:0] cnt;
    } usbee_ep_s;
endpackage

// ===== tb/usbee_checker.sv
// Purpose: port-level checks on the endpoint engine
// Assumes: one clock, synchronous active-high reset
// Notes: register contents are judged by the bench
`timescale 1ns/10ps
`default_nettype none
module usbee_checker (
    input wire logic clock_in, // clock
    input wire logic rst_in, // reset
    input wire logic [usbee_pkg::ADDR_W-1:0] paddr_in, // address
    input wire logic psel_in, // select
    input wire logic penable_in, // enable
    input wire logic pwrite_in, // direction
    input wire logic [31:0] pwdata_in, // write data
    input wire logic [31:0] prdata_out, // read data
    input wire logic pready_out, // ready
    input wire logic pslverr_out, // error
    input wire usbee_pkg::usbee_link_in_s link_in_in, // link events
    input wire usbee_pkg::usbee_link_out_s link_out_out, // transmit
    input wire logic irq_out // interrupt
);
    import usbee_pkg::*;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    a_ready_one_wait: assert property (
        $rose(penable_in) && psel_in |=> pready_out)
        else $error("ready late");
    a_ready_one_cycle: assert property (pready_out |=> !pready_out)
        else $error("ready held");
    a_err_needs_ready: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    a_read_upper_zero: assert property (
        pready_out |-> prdata_out[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_unmapped_err: assert property (
        pready_out && paddr_in > A_DATA |-> pslverr_out)
        else $error("unmapped address accepted");
    a_mapped_ok: assert property (
        pready_out && paddr_in <= A_DATA && paddr_in[1:0] == 2'b00
        |-> !pslverr_out)
        else $error("mapped address refused");
    a_stall_one_pulse: assert property (
        link_out_out.stall |=> !link_out_out.stall)
        else $error("stall held");
    a_stall_after_tok: assert property (
        link_out_out.stall |-> $past(link_in_in.tok_valid)
        && !$past(link_in_in.tok_kind[1]))
        else $error("stall without token");
    a_tx_hold: assert property (
        link_out_out.tx_valid && !link_in_in.tx_accept
        && !link_in_in.bus_reset_end
        |=> link_out_out.tx_valid && $stable(link_out_out.tx_byte))
        else $error("transmit byte dropped");
    a_last_valid: assert property (
        link_out_out.tx_last |-> link_out_out.tx_valid)
        else $error("last without valid");
endmodule
bind usbee_endpoint_engine usbee_checker usbee_checker_i (
    .clock_in(clock_in), .rst_in(rst_in), .paddr_in(paddr_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .link_in_in(link_in_in), .link_out_out(link_out_out),
    .irq_out(irq_out));
`default_nettype wire

// ===== tb/usbee_host_model.sv
// Purpose: behavioural usb host on the link side of the engine
// Assumes: tasks are entered just after a rising edge
// Notes: idle data lines carry the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module usbee_host_model (
    input wire logic clock_in, // clock
    input wire usbee_pkg::usbee_link_out_s link_out_out, // from engine
    output var usbee_pkg::usbee_link_in_s link_in_out // to engine
);
    import usbee_pkg::*;
    logic slow = 1'b0;
    logic [7:0] got [$];
    int stalls = 0;
    initial link_in_out = '0;
    // slow mode accepts every other cycle to stress the hold
    always @(posedge clock_in) begin
        link_in_out.tx_accept <= slow ? ~link_in_out.tx_accept : 1'b1;
        if (link_out_out.tx_valid === 1'b1
            && link_in_out.tx_accept === 1'b1) begin
            got.push_back(link_out_out.tx_byte);
        end
        if (link_out_out.stall === 1'b1) begin
            stalls++;
        end
    end
    task automatic tok(input usbee_tok_e k, input logic [1:0] ep,
                       input logic [10:0] fr, input logic ok);
        link_in_out.tok_valid <= 1'b1;
        link_in_out.tok_kind <= k;
        link_in_out.tok_ep <= ep;
        link_in_out.tok_frame <= fr;
        link_in_out.tok_crc_ok <= ok;
        @(posedge clock_in);
        link_in_out.tok_valid <= 1'b0;
        link_in_out.tok_frame <= ~fr;
        link_in_out.tok_crc_ok <= ~ok;
        @(posedge clock_in);
    endtask
    task automatic pkt(input usbee_tok_e k, input logic [1:0] ep,
                       input int n, input logic [7:0] b, input logic ok);
        tok(k, ep, 11'h000, 1'b1);
        for (int i = 0; i < n; i++) begin
            link_in_out.rx_valid <= 1'b1;
            link_in_out.rx_byte <= b + 8'(i);
            @(posedge clock_in);
            link_in_out.rx_valid <= 1'b0;
            link_in_out.rx_byte <= ~(b + 8'(i));
            @(posedge clock_in);
        end
        link_in_out.rx_end <= 1'b1;
        link_in_out.rx_crc_ok <= ok;
        @(posedge clock_in);
        link_in_out.rx_end <= 1'b0;
        link_in_out.rx_crc_ok <= ~ok;
        @(posedge clock_in);
    endtask
    task automatic rst_end();
        link_in_out.bus_reset_end <= 1'b1;
        @(posedge clock_in);
        link_in_out.bus_reset_end <= 1'b0;
        @(posedge clock_in);
    endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: self-checking bench for the usb endpoint engine
// Assumes: bench plays firmware over apb, host model drives link
// Notes: toggle tracking is internal and left unobserved
`timescale 1ns/10ps
`default_nettype none
module tb;
    import usbee_pkg::*;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [ADDR_W-1:0] paddr_in = '0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [31:0] pwdata_in = '0;
    logic [31:0] prdata_out, q;
    logic pready_out, pslverr_out, irq_out, er;
    logic [7:0] cfg [4] = '{8'h01, 8'h03, 8'h0B, 8'h07};
    usbee_link_in_s link_in;
    usbee_link_out_s link_out;
    int error_cnt = 0;
    int checks_done = 0;
    usbee_endpoint_engine usbee_endpoint_engine_i (
        .clock_in(clock_in), .rst_in(rst_in), .paddr_in(paddr_in),
        .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .link_in_in(link_in),
        .link_out_out(link_out), .irq_out(irq_out));
    usbee_host_model usbee_host_model_i (.clock_in(clock_in),
        .link_out_out(link_out), .link_in_out(link_in));
    initial begin
        forever #20 clock_in = ~clock_in;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clock_in);
        end while (pready_out !== 1'b1);
        q = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock_in);
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge clock_in);
        rst_in <= 1'b0;
        w(A_IEN, 32'h07);
        for (int i = 0; i < 4; i++) begin
            w(A_SEL, 32'(i));
            w(A_CFG, 32'(cfg[i]));
        end
        w(A_SEL, 32'h01);
        usbee_host_model_i.pkt(TK_OUT, 2'd1, 3, 8'hA0, 1'b0);
        rc(A_STATUS, 32'h0A);
        chk(irq_out, 1'b1);
        rc(A_COUNT, 32'h03);
        w(A_SEL, 32'h02);
        rc(A_STATUS, 32'h00);
        w(A_SEL, 32'h01);
        usbee_host_model_i.pkt(TK_OUT, 2'd1, 2, 8'hC0, 1'b1);
        rc(A_COUNT, 32'h03);
        for (int i = 0; i < 3; i++) begin
            rc(A_DATA, 32'hA0 + i);
        end
        w(A_STATUS, 32'h00);
        usbee_host_model_i.pkt(TK_OUT, 2'd1, 10, 8'h10, 1'b1);
        rc(A_STATUS, 32'h02);
        rc(A_COUNT, 32'(CNT_MAX));
        for (int i = 0; i < 8; i++) begin
            rc(A_DATA, 32'h10 + i);
        end
        w(A_STATUS, 32'h00);
        usbee_host_model_i.pkt(TK_OUT, 2'd1, 0, 8'h00, 1'b1);
        rc(A_COUNT, 32'h00);
        w(A_STATUS, 32'h00);
        w(A_SEL, 32'h02);
        usbee_host_model_i.pkt(TK_OUT, 2'd2, 2, 8'h20, 1'b1);
        usbee_host_model_i.pkt(TK_OUT, 2'd2, 1, 8'h30, 1'b1);
        rc(A_STATUS, 32'h42);
        rc(A_COUNT, 32'h02);
        rc(A_DATA, 32'h20);
        rc(A_DATA, 32'h21);
        w(A_STATUS, 32'h40);
        rc(A_COUNT, 32'h01);
        rc(A_DATA, 32'h30);
        w(A_STATUS, 32'h00);
        usbee_host_model_i.pkt(TK_OUT, 2'd2, 1, 8'h40, 1'b1);
        rc(A_STATUS, 32'h02);
        w(A_STATUS, 32'h80);
        w(A_SEL, 32'h01);
        w(A_STATUS, 32'h80);
        usbee_host_model_i.tok(TK_IN, 2'd1, 11'h000, 1'b1);
        repeat (12) @(posedge clock_in);
        chk(32'(usbee_host_model_i.got.size()), 32'h0);
        for (int i = 0; i < 3; i++) begin
            w(A_DATA, 32'h50 + i);
        end
        w(A_STATUS, 32'h90);
        rc(A_STATUS, 32'h90);
        usbee_host_model_i.slow = 1'b1;
        usbee_host_model_i.tok(TK_IN, 2'd1, 11'h000, 1'b1);
        repeat (30) @(posedge clock_in);
        chk(32'(usbee_host_model_i.got.size()), 32'h3);
        for (int i = 0; i < 3; i++) begin
            chk(usbee_host_model_i.got[i], 32'h50 + i);
        end
        rc(A_STATUS, 32'h81);
        chk(irq_out, 1'b1);
        w(A_STATUS, 32'h80);
        usbee_host_model_i.slow = 1'b0;
        w(A_SEL, 32'h02);
        w(A_DATA, 32'h60);
        w(A_STATUS, 32'h90);
        rc(A_STATUS, 32'h80);
        w(A_DATA, 32'h70);
        w(A_STATUS, 32'h90);
        repeat (2) begin
            usbee_host_model_i.tok(TK_IN, 2'd2, 11'h000, 1'b1);
            repeat (20) @(posedge clock_in);
        end
        chk(32'(usbee_host_model_i.got.size()), 32'h5);
        chk(usbee_host_model_i.got[4], 32'h70);
        w(A_SEL, 32'h03);
        w(A_STATUS, 32'h20);
        usbee_host_model_i.tok(TK_IN, 2'd3, 11'h000, 1'b1);
        rc(A_STATUS, 32'h28);
        chk(32'(usbee_host_model_i.stalls), 32'h1);
        w(A_SEL, 32'h00);
        w(A_STATUS, 32'h20);
        usbee_host_model_i.pkt(TK_SETUP, 2'd0, 8, 8'h00, 1'b1);
        rc(A_STATUS, 32'h04);
        w(A_EPRST, 32'h01);
        rc(A_STATUS, 32'h00);
        usbee_host_model_i.tok(TK_SOF, 2'd0, 11'h5A3, 1'b1);
        rc(A_EVENT, 32'h02);
        rc(A_FLO, 32'hA3);
        rc(A_FHI, 32'h0D);
        usbee_host_model_i.tok(TK_SOF, 2'd0, 11'h012, 1'b0);
        rc(A_FLO, 32'h12);
        rc(A_FHI, 32'h10);
        w(A_EVENT, 32'h00);
        rc(A_EVENT, 32'h00);
        w(A_SEL, 32'h01);
        usbee_host_model_i.rst_end();
        rc(A_EVENT, 32'h01);
        rc(A_SEL, 32'h00);
        rc(A_FLO, 32'h00);
        chk(irq_out, 1'b1);
        apb(1'b0, 8'h40, 32'h0);
        chk(er, 1'b1);
        rc(A_EPRST, 32'h00);
        summarize();
    end
endmodule
`default_nettype wire
